// ===== verilog/pwsh_pkg.sv
// Package of register offsets, bit positions and timing constants for the write/start handshake.
package pwsh_pkg;

   // Register word addresses as seen by the host.
   localparam logic [15:0] ADDR_OP_SELECT     = 16'h0105;
   localparam logic [15:0] ADDR_FIXED_IN      = 16'h0106;
   localparam logic [15:0] ADDR_WRITE_REQ     = 16'h0114;
   localparam logic [15:0] ADDR_WRITE_ID      = 16'h0115;
   localparam logic [15:0] ADDR_WRITE_LOW     = 16'h0116;
   localparam logic [15:0] ADDR_WRITE_HIGH    = 16'h0117;
   localparam logic [15:0] ADDR_FIXED_OUT     = 16'h011e;
   localparam logic [15:0] ADDR_ACCESS_STATUS = 16'h012c;
   localparam logic [15:0] ADDR_ID_ECHO       = 16'h012d;

   // Bit positions inside the registers.
   localparam int BIT_WRITE_REQ = 0;
   localparam int BIT_START     = 3;
   localparam int BIT_READY     = 5;
   localparam int BIT_WRITE_END = 8;

   // Reset values of the writable registers.
   localparam logic [15:0] RESET_WORD = 16'h0000;

   // Default first three IP octets.
   localparam logic [23:0] IP_PREFIX_DEFAULT = 24'hc0a801;

   // Indicator blink half period in time and cycles at 20 MHz.
   localparam int CLK_HZ       = 20_000_000;
   localparam int BLINK_MS     = 250;
   localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;

   // Handshake states of the parameter write sequencer.
   typedef enum logic [1:0] {
      PWSH_WR_IDLE,
      PWSH_WR_APPLY,
      PWSH_WR_DONE
   } pwsh_wr_state_t;

endpackage : pwsh_pkg

// ===== verilog/pwsh_blinker.sv
// Free-running blink source shared by the power alarm and module status indicators.
`timescale 1ns/1ps
`default_nettype none
module pwsh_blinker #(
   parameter int HALF_CYCLES = pwsh_pkg::BLINK_CYCLES
) (
   input  wire logic clk,
   input  wire logic reset_n,
   output var  logic blink_q
);

   logic [23:0] count_q;   // Cycles left in the present half period.
   logic [23:0] count_d;   // Next count.
   logic        blink_d;   // Next phase.

   // The phase toggles at the end of each half period.
   always_comb begin
      count_d = count_q - 24'h000001;
      blink_d = blink_q;
      if (count_q == 24'h000000) begin
         count_d = 24'(HALF_CYCLES - 1);
         blink_d = ~blink_q;
      end
   end

   // Registers only.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         count_q <= 24'(HALF_CYCLES - 1);
         blink_q <= 1'b0;
      end else begin
         count_q <= count_d;
         blink_q <= blink_d;
      end
   end

endmodule : pwsh_blinker
`default_nettype wire

// ===== verilog/pwsh_core.sv
// Host register handshake for parameter writes, operation start, IP switch and indicators.
`timescale 1ns/1ps
`default_nettype none
module pwsh_core #(
   parameter int          BLINK_HALF = pwsh_pkg::BLINK_CYCLES,
   parameter logic [23:0] IP_PREFIX  = pwsh_pkg::IP_PREFIX_DEFAULT
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        reg_wr_en,
   input  wire logic        reg_rd_en,
   input  wire logic [15:0] reg_addr,
   input  wire logic [15:0] reg_wr_data,
   output var  logic [15:0] reg_rd_data_q,
   output var  logic        reg_rd_valid_q,
   output var  logic        param_wr_strobe_q,
   output var  logic [15:0] param_wr_id_q,
   output var  logic [31:0] param_wr_value_q,
   input  wire logic        param_wr_ack,
   output var  logic        op_start_q,
   output var  logic [15:0] op_select_q,
   input  wire logic        op_busy,
   input  wire logic [7:0]  ip_octet_switch,
   output var  logic [31:0] ip_address_q,
   input  wire logic        alarm_active,
   input  wire logic        internal_error,
   input  wire logic        settings_corrupt,
   input  wire logic        comm_active,
   input  wire logic        comm_error,
   output var  logic        power_alarm_indicator_q,
   output var  logic        module_status_indicator_q,
   output var  logic        network_status_indicator_q
);

   ////////////////////////////////////////////////////////////////////////////////
   // Host-written registers.

   logic [15:0] fixed_in_q, fixed_in_d;     // Start and other fixed inputs.
   logic [15:0] wr_req_q, wr_req_d;         // Write request word.
   logic [15:0] wr_id_q, wr_id_d;           // Staged parameter identifier.
   logic [15:0] wr_lo_q, wr_lo_d;           // Staged value, lower half.
   logic [15:0] wr_hi_q, wr_hi_d;           // Staged value, upper half.
   logic [15:0] op_select_d;                // Next operation selection.

   // Host writes land here; the host stages id and value before requesting.
   always_comb begin
      op_select_d = op_select_q;
      fixed_in_d  = fixed_in_q;
      wr_req_d    = wr_req_q;
      wr_id_d     = wr_id_q;
      wr_lo_d     = wr_lo_q;
      wr_hi_d     = wr_hi_q;
      if (reg_wr_en) begin
         unique case (reg_addr)
            pwsh_pkg::ADDR_OP_SELECT:  op_select_d = reg_wr_data;
            pwsh_pkg::ADDR_FIXED_IN:   fixed_in_d  = reg_wr_data;
            pwsh_pkg::ADDR_WRITE_REQ:  wr_req_d    = reg_wr_data;
            pwsh_pkg::ADDR_WRITE_ID:   wr_id_d     = reg_wr_data;
            pwsh_pkg::ADDR_WRITE_LOW:  wr_lo_d     = reg_wr_data;
            pwsh_pkg::ADDR_WRITE_HIGH: wr_hi_d     = reg_wr_data;
            default: ;   // Read-only and unmapped addresses ignore writes.
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Parameter write sequencer.

   pwsh_pkg::pwsh_wr_state_t wr_state_q, wr_state_d;   // Sequencer state.
   logic        req_prev_q;                             // Request bit one cycle ago.
   logic        wr_end_q, wr_end_d;                     // Write-done flag.
   logic [15:0] id_echo_q, id_echo_d;                   // Echoed identifier.
   logic        strobe_d;                               // Next apply strobe.
   logic [15:0] pid_d;                                  // Next applied identifier.
   logic [31:0] pval_d;                                 // Next applied value.
   logic        req_bit;                                // Live request bit.

   assign req_bit = wr_req_q[pwsh_pkg::BIT_WRITE_REQ];

   // Only a rising request starts a write, so a request held high after completion
   // cannot apply the value twice.
   always_comb begin
      wr_state_d = wr_state_q;
      wr_end_d   = wr_end_q;
      id_echo_d  = id_echo_q;
      strobe_d   = 1'b0;
      pid_d      = param_wr_id_q;
      pval_d     = param_wr_value_q;
      unique case (wr_state_q)
         pwsh_pkg::PWSH_WR_IDLE: begin
            if (req_bit && !req_prev_q) begin
               strobe_d   = 1'b1;
               pid_d      = wr_id_q;
               pval_d     = {wr_hi_q, wr_lo_q};
               wr_state_d = pwsh_pkg::PWSH_WR_APPLY;
            end
         end
         pwsh_pkg::PWSH_WR_APPLY: begin
            if (param_wr_ack) begin
               wr_end_d   = 1'b1;
               id_echo_d  = param_wr_id_q;
               wr_state_d = pwsh_pkg::PWSH_WR_DONE;
            end
         end
         pwsh_pkg::PWSH_WR_DONE: begin
            if (!req_bit) begin
               wr_end_d   = 1'b0;
               wr_state_d = pwsh_pkg::PWSH_WR_IDLE;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Operation start and ready.

   logic start_prev_q;           // Start bit one cycle ago.
   logic op_start_d;             // Next start pulse.
   logic ready_q, ready_d;       // Ready flag.
   logic start_bit;              // Live start bit.

   assign start_bit = fixed_in_q[pwsh_pkg::BIT_START];

   // Ready drops the cycle start is accepted and stays low while busy; it returns only
   // once the host released start, so the same start level is not run again.
   always_comb begin
      op_start_d = 1'b0;
      ready_d    = ready_q;
      if (start_bit && !start_prev_q && ready_q) begin
         op_start_d = 1'b1;
         ready_d    = 1'b0;
      end else if (!ready_q && !op_busy && !op_start_q && !start_bit) begin
         ready_d    = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // IP switch, captured once after power-up reset release.

   logic [7:0] sw_s1_q, sw_s2_q; // Two-stage synchroniser for the switch.
   logic       ip_taken_q;       // Set once the octet has been captured.
   logic [1:0] ip_wait_q;        // Lets the synchroniser fill before capture.

   ////////////////////////////////////////////////////////////////////////////////
   // Indicators.

   logic blink;                  // Shared blink phase.
   logic int_err_q;              // Internal error seen since reset; only a reset clears it.

   pwsh_blinker #(.HALF_CYCLES(BLINK_HALF)) u_blink (
      .clk     (clk),
      .reset_n (reset_n),
      .blink_q (blink)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Read decode.

   logic [15:0] rd_d;            // Next read word.

   // Unmapped reads return zero.
   always_comb begin
      unique case (reg_addr)
         pwsh_pkg::ADDR_OP_SELECT:     rd_d = op_select_q;
         pwsh_pkg::ADDR_FIXED_IN:      rd_d = fixed_in_q;
         pwsh_pkg::ADDR_WRITE_REQ:     rd_d = wr_req_q;
         pwsh_pkg::ADDR_WRITE_ID:      rd_d = wr_id_q;
         pwsh_pkg::ADDR_WRITE_LOW:     rd_d = wr_lo_q;
         pwsh_pkg::ADDR_WRITE_HIGH:    rd_d = wr_hi_q;
         pwsh_pkg::ADDR_FIXED_OUT:     rd_d = 16'(ready_q) << pwsh_pkg::BIT_READY;
         pwsh_pkg::ADDR_ACCESS_STATUS: rd_d = 16'(wr_end_q) << pwsh_pkg::BIT_WRITE_END;
         pwsh_pkg::ADDR_ID_ECHO:       rd_d = id_echo_q;
         default:                      rd_d = 16'h0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // All registers except the IP switch capture.

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         op_select_q <= pwsh_pkg::RESET_WORD;
         fixed_in_q  <= pwsh_pkg::RESET_WORD;
         wr_req_q    <= pwsh_pkg::RESET_WORD;
         wr_id_q     <= pwsh_pkg::RESET_WORD;
         wr_lo_q     <= pwsh_pkg::RESET_WORD;
         wr_hi_q     <= pwsh_pkg::RESET_WORD;
         wr_state_q  <= pwsh_pkg::PWSH_WR_IDLE;
         req_prev_q  <= 1'b0;
         wr_end_q    <= 1'b0;
         id_echo_q   <= pwsh_pkg::RESET_WORD;
         param_wr_strobe_q <= 1'b0;
         param_wr_id_q     <= pwsh_pkg::RESET_WORD;
         param_wr_value_q  <= 32'h00000000;
         start_prev_q <= 1'b0;
         op_start_q   <= 1'b0;
         ready_q      <= 1'b1;
         reg_rd_data_q  <= 16'h0000;
         reg_rd_valid_q <= 1'b0;
         power_alarm_indicator_q    <= 1'b0;
         module_status_indicator_q  <= 1'b0;
         int_err_q                  <= 1'b0;
         network_status_indicator_q <= 1'b0;
      end else begin
         op_select_q <= op_select_d;
         fixed_in_q  <= fixed_in_d;
         wr_req_q    <= wr_req_d;
         wr_id_q     <= wr_id_d;
         wr_lo_q     <= wr_lo_d;
         wr_hi_q     <= wr_hi_d;
         wr_state_q  <= wr_state_d;
         req_prev_q  <= req_bit;
         wr_end_q    <= wr_end_d;
         id_echo_q   <= id_echo_d;
         param_wr_strobe_q <= strobe_d;
         param_wr_id_q     <= pid_d;
         param_wr_value_q  <= pval_d;
         start_prev_q <= start_bit;
         op_start_q   <= op_start_d;
         ready_q      <= ready_d;
         reg_rd_data_q  <= rd_d;
         reg_rd_valid_q <= reg_rd_en;
         power_alarm_indicator_q    <= alarm_active & blink;
         // The error stays latched after its source drops, so the lamp outlives it.
         int_err_q                  <= int_err_q | internal_error;
         module_status_indicator_q  <= int_err_q | internal_error | (settings_corrupt & blink);
         network_status_indicator_q <= comm_active & comm_error;
      end
   end

   // Switch capture: synchronise, wait three edges, take once, never again until reset.
   always_ff @(posedge clk) begin
      sw_s1_q <= ip_octet_switch;
      sw_s2_q <= sw_s1_q;
      if (!reset_n) begin
         ip_taken_q   <= 1'b0;
         ip_wait_q    <= 2'b00;
         ip_address_q <= {IP_PREFIX, 8'h00};
      end else if (!ip_taken_q) begin
         ip_wait_q <= ip_wait_q + 2'b01;
         if (ip_wait_q == 2'b11) begin
            ip_address_q <= {IP_PREFIX, sw_s2_q};
            ip_taken_q   <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   sequence s_req_rise;
      req_bit && !req_prev_q && wr_state_q == pwsh_pkg::PWSH_WR_IDLE;
   endsequence

   a_write_strobe_issue: assert property (@(posedge clk) disable iff (!reset_n)
      s_req_rise |=> param_wr_strobe_q && param_wr_id_q == $past(wr_id_q))
      else $error("write strobe missing after request rise");
   a_write_done_echo: assert property (@(posedge clk) disable iff (!reset_n)
      wr_state_q == pwsh_pkg::PWSH_WR_APPLY && param_wr_ack |=> wr_end_q && id_echo_q == param_wr_id_q)
      else $error("done flag or echo wrong");
   a_write_done_clear: assert property (@(posedge clk) disable iff (!reset_n)
      wr_state_q == pwsh_pkg::PWSH_WR_DONE && !req_bit |=> !wr_end_q)
      else $error("done flag not cleared");
   a_single_write_edge: assert property (@(posedge clk) disable iff (!reset_n)
      param_wr_strobe_q |=> !param_wr_strobe_q)
      else $error("second strobe without new request");
   a_start_pulse_ready: assert property (@(posedge clk) disable iff (!reset_n)
      start_bit && !start_prev_q && ready_q |=> op_start_q && !ready_q)
      else $error("start not launched");
   a_ready_low_busy: assert property (@(posedge clk) disable iff (!reset_n)
      op_busy |=> !ready_q)
      else $error("ready high while busy");
   a_status_ready_bit: assert property (@(posedge clk) disable iff (!reset_n)
      reg_rd_en && reg_addr == pwsh_pkg::ADDR_FIXED_OUT |=> reg_rd_data_q[pwsh_pkg::BIT_READY] == $past(ready_q))
      else $error("ready bit read wrong");
   a_ip_switch_frozen: assert property (@(posedge clk) disable iff (!reset_n)
      ip_taken_q && $past(ip_taken_q) |-> $stable(ip_address_q))
      else $error("ip changed after capture");
   a_alarm_led_dark: assert property (@(posedge clk) disable iff (!reset_n)
      !alarm_active |=> !power_alarm_indicator_q)
      else $error("alarm led lit without alarm");
   a_net_led_idle: assert property (@(posedge clk) disable iff (!reset_n)
      !comm_active |=> !network_status_indicator_q)
      else $error("network led lit while idle");
   a_error_led_hold: assert property (@(posedge clk) disable iff (!reset_n)
      int_err_q |=> module_status_indicator_q)
      else $error("module led dark after internal error");

endmodule : pwsh_core
`default_nettype wire

// ===== sim/pwsh_motion_model.sv
// Motion-side responder that acknowledges parameter stores and runs operations.
`timescale 1ns/1ps
`default_nettype none
module pwsh_motion_model #(
   parameter int BUSY_CYCLES = 30
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic param_wr_strobe_q,
   input  wire logic op_start_q,
   output var  logic param_wr_ack,
   output var  logic op_busy
);
   int ack_wait  = 0; // Cycles left before the store is acknowledged.
   int busy_left = 0; // Cycles left in the running operation.

   assign op_busy = (busy_left != 0);

   // A random delay makes both prompt and slow acknowledges occur.
   always @(posedge clk) begin
      param_wr_ack <= 1'b0;
      if (!reset_n) begin
         ack_wait <= 0;
      end else if (param_wr_strobe_q) begin
         ack_wait <= 1 + ($urandom % 6);
      end else if (ack_wait == 1) begin
         ack_wait     <= 0;
         param_wr_ack <= 1'b1;
      end else if (ack_wait > 1) begin
         ack_wait <= ack_wait - 1;
      end
   end

   // Busy spans a fixed time after each start pulse.
   always @(posedge clk) begin
      if (!reset_n) busy_left <= 0;
      else if (op_start_q) busy_left <= BUSY_CYCLES;
      else if (busy_left > 0) busy_left <= busy_left - 1;
   end
endmodule : pwsh_motion_model
`default_nettype wire

// ===== sim/param_write_start_handshake_tb_top.sv
// Self-checking bench for the write/start handshake core.
`timescale 1ns/1ps
`default_nettype none
module param_write_start_handshake_tb_top;
   logic        clk, reset_n, reg_wr_en, reg_rd_en;
   logic [15:0] reg_addr, reg_wr_data, reg_rd_data_q, param_wr_id_q, op_select_q;
   logic        reg_rd_valid_q, param_wr_strobe_q, param_wr_ack, op_start_q, op_busy;
   logic [31:0] param_wr_value_q, ip_address_q;
   logic [7:0]  ip_octet_switch;
   logic        alarm_active, internal_error, settings_corrupt, comm_active, comm_error;
   logic        power_alarm_indicator_q, module_status_indicator_q;
   logic        network_status_indicator_q;
   logic [15:0] rq[$];  // Expected read words, oldest first.
   logic [15:0] sq[$];  // Expected selection at each start pulse.
   logic [47:0] pq[$];  // Expected identifier and value at each store.
   logic [15:0] id, sel;
   logic [31:0] v;
   int          bad_count = 0, n_compared = 0, cyc = 0, n;
   wire  [2:0]  leds = {power_alarm_indicator_q, module_status_indicator_q,
                        network_status_indicator_q};

   pwsh_core #(.BLINK_HALF(4)) u_dut (.clk, .reset_n, .reg_wr_en, .reg_rd_en, .reg_addr,
      .reg_wr_data, .reg_rd_data_q, .reg_rd_valid_q, .param_wr_strobe_q, .param_wr_id_q,
      .param_wr_value_q, .param_wr_ack, .op_start_q, .op_select_q, .op_busy,
      .ip_octet_switch, .ip_address_q, .alarm_active, .internal_error, .settings_corrupt,
      .comm_active, .comm_error, .power_alarm_indicator_q, .module_status_indicator_q,
      .network_status_indicator_q);
   pwsh_motion_model u_motion (.clk, .reset_n, .param_wr_strobe_q, .op_start_q,
      .param_wr_ack, .op_busy);

   ////////////////////////////////////////////////////////////////////////////////
   // A 50 ns clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk16(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t word %h expected %h", $time, g, e);
      end
   endtask : chk16

   task automatic chkw(input logic [47:0] g, input logic [47:0] e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t value %h expected %h", $time, g, e);
      end
   endtask : chkw

   task automatic conclude;
      if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude

   // One register write; the strobe drops a cycle later so words never merge.
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_wr_en   = 1'b1;
      reg_addr    = a;
      reg_wr_data = d;
      @(negedge clk);
      reg_wr_en = 1'b0;
   endtask : wr

   // One register read; the expected word waits in the queue for the monitor.
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      @(negedge clk);
      rq.push_back(e);
      reg_rd_en = 1'b1;
      reg_addr  = a;
      @(negedge clk);
      reg_rd_en = 1'b0;
   endtask : rd

   // Counts lit samples of one indicator after letting its register settle.
   task automatic led_cnt(input int i, output int c);
      c = 0;
      repeat (3) @(negedge clk);
      repeat (24) begin
         @(negedge clk);
         c += (leds[i] === 1'b1);
      end
   endtask : led_cnt

   ////////////////////////////////////////////////////////////////////////////////
   // Monitors take the oldest note whenever a result shows at the outputs.
   always @(negedge clk) begin
      if (reg_rd_valid_q === 1'b1) chk16(reg_rd_data_q, rq.size() ? rq.pop_front() : 'x);
      if (param_wr_strobe_q === 1'b1)
         chkw({param_wr_id_q, param_wr_value_q}, pq.size() ? pq.pop_front() : 'x);
      if (op_start_q === 1'b1) chk16(op_select_q, sq.size() ? sq.pop_front() : 'x);
   end

   // A hang is cut short well beyond the expected run length.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         conclude();
      end
   end

   initial begin
      {reset_n, reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = '0;
      {alarm_active, internal_error, settings_corrupt, comm_active, comm_error} = '0;
      ip_octet_switch = 8'h02;
      void'($urandom(32'h61aa));
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      repeat (6) @(negedge clk);
      chkw({16'h0, ip_address_q}, {16'h0, pwsh_pkg::IP_PREFIX_DEFAULT, 8'h02});
      ip_octet_switch = 8'h55;
      // Every transaction below shares one session with the block.
      rd(pwsh_pkg::ADDR_FIXED_OUT, 16'h0020);
      rd(pwsh_pkg::ADDR_ACCESS_STATUS, 16'h0000);
      rd(16'h0200, 16'h0000);
      chkw({16'h0, ip_address_q}, {16'h0, pwsh_pkg::IP_PREFIX_DEFAULT, 8'h02});
      // Staged stores, with a request held high that must not repeat.
      for (int i = 0; i < 3; i++) begin
         id = (i == 0) ? 16'h0c21 : 16'($urandom);
         v  = (i == 0) ? 32'h00001388 : $urandom;
         wr(pwsh_pkg::ADDR_WRITE_ID, id);
         wr(pwsh_pkg::ADDR_WRITE_LOW, v[15:0]);
         wr(pwsh_pkg::ADDR_WRITE_HIGH, v[31:16]);
         pq.push_back({id, v});
         wr(pwsh_pkg::ADDR_WRITE_REQ, 16'h0001);
         repeat (14) @(negedge clk);
         rd(pwsh_pkg::ADDR_ACCESS_STATUS, 16'h0100);
         rd(pwsh_pkg::ADDR_ID_ECHO, id);
         wr(pwsh_pkg::ADDR_WRITE_REQ, 16'h0001);
         repeat (14) @(negedge clk);
         rd(pwsh_pkg::ADDR_ACCESS_STATUS, 16'h0100);
         wr(pwsh_pkg::ADDR_WRITE_REQ, 16'h0000);
         repeat (3) @(negedge clk);
         rd(pwsh_pkg::ADDR_ACCESS_STATUS, 16'h0000);
      end
      // Start an operation, then try a second start while not ready.
      sel = 16'($urandom);
      rd(pwsh_pkg::ADDR_FIXED_OUT, 16'h0020);
      wr(pwsh_pkg::ADDR_OP_SELECT, sel);
      rd(pwsh_pkg::ADDR_OP_SELECT, sel);
      sq.push_back(sel);
      wr(pwsh_pkg::ADDR_FIXED_IN, 16'h0008);
      repeat (2) @(negedge clk);
      rd(pwsh_pkg::ADDR_FIXED_OUT, 16'h0000);
      wr(pwsh_pkg::ADDR_FIXED_IN, 16'h0000);
      wr(pwsh_pkg::ADDR_FIXED_IN, 16'h0008);
      rd(pwsh_pkg::ADDR_FIXED_OUT, 16'h0000);
      wr(pwsh_pkg::ADDR_FIXED_IN, 16'h0000);
      repeat (40) @(negedge clk);
      rd(pwsh_pkg::ADDR_FIXED_OUT, 16'h0020);
      // Indicators: dark when idle, then each cause in turn.
      for (int i = 0; i < 3; i++) begin
         led_cnt(i, n);
         chkw(48'(n), 48'h0);
      end
      alarm_active = 1'b1;
      led_cnt(2, n);
      chkw(48'(n > 8 && n < 16), 48'h1);
      alarm_active     = 1'b0;
      settings_corrupt = 1'b1;
      led_cnt(1, n);
      chkw(48'(n > 8 && n < 16), 48'h1);
      settings_corrupt = 1'b0;
      comm_error       = 1'b1;
      led_cnt(0, n);
      chkw(48'(n), 48'h0);
      comm_active = 1'b1;
      led_cnt(0, n);
      chkw(48'(n), 48'h18);
      comm_error = 1'b0;
      led_cnt(0, n);
      chkw(48'(n), 48'h0);
      internal_error = 1'b1;
      led_cnt(1, n);
      chkw(48'(n), 48'h18);
      internal_error = 1'b0;
      led_cnt(1, n);
      chkw(48'(n), 48'h18);
      // A second power-up takes the new switch value and clears the error.
      ip_octet_switch = 8'h07;
      reset_n         = 1'b0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      repeat (6) @(negedge clk);
      chkw({16'h0, ip_address_q}, {16'h0, pwsh_pkg::IP_PREFIX_DEFAULT, 8'h07});
      led_cnt(1, n);
      chkw(48'(n), 48'h0);
      chkw(48'(rq.size() + pq.size() + sq.size()), 48'h0);
      // The session is closed only once every answer has been taken.
      conclude();
   end
endmodule : param_write_start_handshake_tb_top
`default_nettype wire
